// ---- design/intc_pkg.sv ----
package intc_pkg;

  // ==================================================================
  // Register offsets
  localparam logic [7:0] OFS_TIMER_CTRL  = 8'h88;  // timer_ctrl_and_pin_requests
  localparam logic [7:0] OFS_EXT_FLAGS   = 8'h91;  // extended_request_flags
  localparam logic [7:0] OFS_PIN0_EN     = 8'h96;  // pin_group0_enables
  localparam logic [7:0] OFS_PIN0_FLAGS  = 8'h97;  // pin_group0_edge_flags
  localparam logic [7:0] OFS_PIN1_EN     = 8'hAE;  // pin_group1_enables
  localparam logic [7:0] OFS_PIN1_FLAGS  = 8'hAF;  // pin_group1_edge_flags
  localparam logic [7:0] OFS_BASIC_PRIO  = 8'hB8;  // basic_priority_levels
  localparam logic [7:0] OFS_EXT_PRIO    = 8'hF8;  // extended_priority_levels

  // ==================================================================
  // Reset value, shared by every register of the block
  localparam logic [7:0] REG_RESET       = 8'h00;

  // ==================================================================
  // Field positions in the timer control register
  localparam int TC_TIMER1_OVF  = 7;
  localparam int TC_TIMER1_RUN  = 6;
  localparam int TC_TIMER0_OVF  = 5;
  localparam int TC_TIMER0_RUN  = 4;
  localparam int TC_PIN1_REQ    = 3;
  localparam int TC_PIN0_REQ    = 1;
  // I2C master flag position in the extended flag register
  localparam int EF_I2C_MASTER  = 0;

  // ==================================================================
  // Source indices, also the natural order (lower index wins a tie)
  localparam int          NUM_SRC     = 15;
  localparam logic [3:0]  SRC_PIN0    = 4'h0;
  localparam logic [3:0]  SRC_TIMER0  = 4'h1;
  localparam logic [3:0]  SRC_PIN1    = 4'h2;
  localparam logic [3:0]  SRC_TIMER1  = 4'h3;

  // Pin group widths
  localparam int PIN0_W = 4;
  localparam int PIN1_W = 6;

  // ==================================================================
  // Source flags from the on-chip external peripherals
  typedef struct packed {
    logic [2:0] rtc;          // Second, alarm, quarter-second
    logic [3:0] serial_cec;   // SPI, two I2C slaves, CEC
    logic [5:0] pca;          // One per PCA channel
    logic [1:0] adc_pwm;      // ADC done, PWM
    logic [3:0] comparator;   // Comparators A to D
    logic [1:0] low_voltage;  // Two detectors
  } periph_flags_type;

  // Whole state of the controller
  typedef struct packed {
    logic [PIN0_W-1:0] pin0_prev;    // Last sampled pin levels
    logic [PIN1_W-1:0] pin1_prev;
    logic [PIN0_W-1:0] pin0_flags;   // Latched edges
    logic [PIN1_W-1:0] pin1_flags;
    logic [PIN0_W-1:0] pin0_en;
    logic [PIN1_W-1:0] pin1_en;
    logic              pin0_req;     // Group request bits
    logic              pin1_req;
    logic              tmr0_ovf;
    logic              tmr1_ovf;
    logic              tmr0_run;
    logic              tmr1_run;
    logic              i2cm_flag;
    logic [6:0]        basic_prio;
    logic [7:0]        ext_prio;
    logic [7:0]        rdata;
    logic              irq_valid;
    logic              irq_high;
    logic [3:0]        irq_src;
  } state_type;

endpackage : intc_pkg

// ---- design/intc_core.sv ----
`timescale 1ns/10ps

// How it works
// - Basic priority: seven bits, bit 7 unused.
// - Extended priority: eight peripheral priority bits.
// - Peripheral flag bits read-only, writes ignored.
// - I2C master flag sticky until software clears.
// - Peripheral flag equals OR of sources.
// - Uncleared source keeps the request asserted.
// - Timer 2 and watchdog flags live in peripherals.
// - Timer overflow flags cleared on vector entry.
// - Group request bits reflect flags, writes ignored.
// - Group 0 enables: four bits.
// - Group 0 flag set on edge, sticky.
// - Group 1 enables: six bits, 7-6 unused.
// - Group 1 flag set on edge, sticky.
// - Edges latched per pin, ORed per group.
// - Edge polarity chosen by outside configuration.
// - Group OR latched into request, drives CPU.
// - Uncleared pin flag keeps group request active.
// - Priority bit one means high level.
// - Enabled requests sampled every rising clock edge.
// - High level first; natural order breaks ties.
module intc_core (
  // Clock and reset
  input  wire logic                     i_clk,
  input  wire logic                     i_sys_rst,
  // Register port
  input  wire logic [7:0]               i_addr,
  input  wire logic [7:0]               i_wdata,
  input  wire logic                     i_wr,
  input  wire logic                     i_rd,
  output logic      [7:0]               o_rdata,
  // Peripheral sources
  input  intc_pkg::periph_flags_type    i_periph_flags,
  input  wire logic                     i_i2c_master_event,
  input  wire logic                     i_timer0_overflow,
  input  wire logic                     i_timer1_overflow,
  input  wire logic                     i_timer2_flag,
  input  wire logic                     i_watchdog_flag,
  input  wire logic                     i_uart0_request,
  input  wire logic                     i_uart2_request,
  // Expanded pins and their edge choice (1 = rising)
  input  wire logic [3:0]               i_pin_group0,
  input  wire logic [5:0]               i_pin_group1,
  input  wire logic [3:0]               i_pin_edge_config0,
  input  wire logic [5:0]               i_pin_edge_config1,
  // CPU core side
  input  wire logic [14:0]              i_source_enables,
  input  wire logic                     i_vector_ack,
  input  wire logic [3:0]               i_vector_source,
  output logic                          o_irq_valid,
  output logic                          o_irq_high,
  output logic [3:0]                    o_irq_source,
  output logic                          o_timer0_run,
  output logic                          o_timer1_run
);

  // ==================================================================
  // Helpers

  // Edge seen on each pin: a change that lands on the chosen level
  function automatic logic [5:0] edge_hits(input logic [5:0] cur,
                                           input logic [5:0] prev,
                                           input logic [5:0] cfg);
    edge_hits = (cur ^ prev) & ~(cur ^ cfg);
  endfunction : edge_hits

  // Lowest set index wins, which is the natural order
  function automatic logic [3:0] first_set(input logic [14:0] v);
    first_set = 4'h0;
    for (int i = intc_pkg::NUM_SRC - 1; i >= 0; i--) begin
      if (v[i]) begin
        first_set = 4'(i);
      end
    end
  endfunction : first_set

  // ==================================================================
  // State
  intc_pkg::state_type st_ff;      // Registered state
  intc_pkg::state_type nxt_st;     // Next state

  // Combinational views
  logic [7:0]  ext_flags;          // Extended flag register image
  logic [7:0]  timer_ctrl;         // Timer control register image
  logic [14:0] pending;            // Enabled requests
  logic [14:0] prio_level;         // One bit per source
  logic [14:0] high_pend;          // Pending at the high level
  logic [5:0]  edge0;              // Group 0 edges, upper bits padding
  logic [5:0]  edge1;              // Group 1 edges
  logic        wr_hit_tc;          // Write decodes
  logic        wr_hit_ef;
  logic        wr_hit_f0;
  logic        wr_hit_f1;

  // ==================================================================
  // Register images and request vector
  always_comb begin
    // Each peripheral request is the live OR of its own flags
    ext_flags = {|i_periph_flags.rtc,
                 |i_periph_flags.serial_cec,
                 |i_periph_flags.pca,
                 1'b0,
                 |i_periph_flags.adc_pwm,
                 |i_periph_flags.comparator,
                 |i_periph_flags.low_voltage,
                 st_ff.i2cm_flag};
    timer_ctrl = {st_ff.tmr1_ovf, st_ff.tmr1_run, st_ff.tmr0_ovf, st_ff.tmr0_run,
                  st_ff.pin1_req, 1'b0, st_ff.pin0_req, 1'b0};
    // Timer 2 and watchdog flags are held and cleared in their peripherals
    pending = {ext_flags[7:5], i_watchdog_flag, ext_flags[3:0],
               i_uart2_request, i_timer2_flag, i_uart0_request,
               st_ff.tmr1_ovf, st_ff.pin1_req, st_ff.tmr0_ovf,
               st_ff.pin0_req} & i_source_enables;
    // Source order matches the bit order of both priority registers
    prio_level = {st_ff.ext_prio, st_ff.basic_prio};
    high_pend  = pending & prio_level;
    edge0 = edge_hits({2'b00, i_pin_group0}, {2'b00, st_ff.pin0_prev},
                      {2'b00, i_pin_edge_config0});
    edge1 = edge_hits(i_pin_group1, st_ff.pin1_prev, i_pin_edge_config1);
    wr_hit_tc = i_wr && (i_addr == intc_pkg::OFS_TIMER_CTRL);
    wr_hit_ef = i_wr && (i_addr == intc_pkg::OFS_EXT_FLAGS);
    wr_hit_f0 = i_wr && (i_addr == intc_pkg::OFS_PIN0_FLAGS);
    wr_hit_f1 = i_wr && (i_addr == intc_pkg::OFS_PIN1_FLAGS);
  end

  // ==================================================================
  // Next state
  always_comb begin
    nxt_st = st_ff;

    // Pins are sampled every cycle for edge detection
    nxt_st.pin0_prev = i_pin_group0;
    nxt_st.pin1_prev = i_pin_group1;

    // Pin flags: software writes zero to clear, a new edge wins
    if (wr_hit_f0) begin
      nxt_st.pin0_flags = st_ff.pin0_flags & i_wdata[3:0];
    end
    if (wr_hit_f1) begin
      nxt_st.pin1_flags = st_ff.pin1_flags & i_wdata[5:0];
    end
    // Latching happens whatever the enable, so nothing is missed
    nxt_st.pin0_flags = nxt_st.pin0_flags | edge0[3:0];
    nxt_st.pin1_flags = nxt_st.pin1_flags | edge1;

    // Group requests follow the enabled flags one cycle later;
    // writes to these bits are dropped since they only mirror flags
    nxt_st.pin0_req = |(st_ff.pin0_flags & st_ff.pin0_en);
    nxt_st.pin1_req = |(st_ff.pin1_flags & st_ff.pin1_en);

    // Timer control: only the run bits take software writes
    if (wr_hit_tc) begin
      nxt_st.tmr1_run = i_wdata[intc_pkg::TC_TIMER1_RUN];
      nxt_st.tmr0_run = i_wdata[intc_pkg::TC_TIMER0_RUN];
    end
    // Overflow flags drop on vector entry; an overflow the same cycle wins
    if (i_vector_ack && (i_vector_source == intc_pkg::SRC_TIMER0)) begin
      nxt_st.tmr0_ovf = 1'b0;
    end
    if (i_vector_ack && (i_vector_source == intc_pkg::SRC_TIMER1)) begin
      nxt_st.tmr1_ovf = 1'b0;
    end
    if (i_timer0_overflow) begin
      nxt_st.tmr0_ovf = 1'b1;
    end
    if (i_timer1_overflow) begin
      nxt_st.tmr1_ovf = 1'b1;
    end

    // I2C master flag: only software clears it, never vectoring
    if (wr_hit_ef && !i_wdata[intc_pkg::EF_I2C_MASTER]) begin
      nxt_st.i2cm_flag = 1'b0;
    end
    if (i_i2c_master_event) begin
      nxt_st.i2cm_flag = 1'b1;
    end

    // Plain read/write registers; unused bits are not stored
    if (i_wr) begin
      case (i_addr)
        intc_pkg::OFS_PIN0_EN:    nxt_st.pin0_en    = i_wdata[3:0];
        intc_pkg::OFS_PIN1_EN:    nxt_st.pin1_en    = i_wdata[5:0];
        intc_pkg::OFS_BASIC_PRIO: nxt_st.basic_prio = i_wdata[6:0];
        intc_pkg::OFS_EXT_PRIO:   nxt_st.ext_prio   = i_wdata;
        default:                  nxt_st.rdata      = st_ff.rdata;
      endcase
    end

    // Read data stand the cycle after the strobe, zero otherwise
    nxt_st.rdata = 8'h00;
    if (i_rd) begin
      case (i_addr)
        intc_pkg::OFS_TIMER_CTRL: nxt_st.rdata = timer_ctrl;
        intc_pkg::OFS_EXT_FLAGS:  nxt_st.rdata = ext_flags;
        intc_pkg::OFS_PIN0_EN:    nxt_st.rdata = {4'h0, st_ff.pin0_en};
        intc_pkg::OFS_PIN0_FLAGS: nxt_st.rdata = {4'h0, st_ff.pin0_flags};
        intc_pkg::OFS_PIN1_EN:    nxt_st.rdata = {2'b00, st_ff.pin1_en};
        intc_pkg::OFS_PIN1_FLAGS: nxt_st.rdata = {2'b00, st_ff.pin1_flags};
        intc_pkg::OFS_BASIC_PRIO: nxt_st.rdata = {1'b0, st_ff.basic_prio};
        intc_pkg::OFS_EXT_PRIO:   nxt_st.rdata = st_ff.ext_prio;
        default:                  nxt_st.rdata = 8'h00;
      endcase
    end

    // Arbitration sampled every edge; high level beats natural order
    nxt_st.irq_valid = |pending;
    nxt_st.irq_high  = |high_pend;
    nxt_st.irq_src   = (|high_pend) ? first_set(high_pend)
                                    : first_set(pending);
  end

  // ==================================================================
  // State register, synchronous reset to all zero
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // Outputs straight from the state register
  assign o_rdata      = st_ff.rdata;
  assign o_irq_valid  = st_ff.irq_valid;
  assign o_irq_high   = st_ff.irq_high;
  assign o_irq_source = st_ff.irq_src;
  assign o_timer0_run = st_ff.tmr0_run;
  assign o_timer1_run = st_ff.tmr1_run;

  // ==================================================================
  // Checks
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_sys_rst);

  a_tmr0_vector_clear: assert property (i_vector_ack && i_vector_source == intc_pkg::SRC_TIMER0
      && !i_timer0_overflow |=> !st_ff.tmr0_ovf)
    else $error("timer 0 flag not cleared on vector entry");
  a_tmr0_no_write: assert property (wr_hit_tc && !i_timer0_overflow && !i_vector_ack
      |=> st_ff.tmr0_ovf == $past(st_ff.tmr0_ovf))
    else $error("timer 0 flag changed by a write");
  a_ext_flag_read: assert property (i_rd && i_addr == intc_pkg::OFS_EXT_FLAGS
      |=> o_rdata[7] == $past(|i_periph_flags.rtc))
    else $error("peripheral flag does not mirror its sources");
  a_i2cm_sticky: assert property (st_ff.i2cm_flag && !wr_hit_ef |=> st_ff.i2cm_flag)
    else $error("I2C master flag dropped without a write");
  a_pin0_latch: assert property (edge0[0] |=> st_ff.pin0_flags[0] ##1 st_ff.pin0_req
      || !$past(st_ff.pin0_en[0]) || wr_hit_f0)
    else $error("group 0 edge not latched");
  a_pin1_sticky: assert property (st_ff.pin1_flags[5] && !wr_hit_f1 |=> st_ff.pin1_flags[5])
    else $error("group 1 flag dropped without a write");
  a_group_req_or: assert property (1'b1 |=> st_ff.pin1_req ==
      |($past(st_ff.pin1_flags) & $past(st_ff.pin1_en)))
    else $error("group 1 request is not the OR of enabled flags");
  a_high_first: assert property (|high_pend |=> o_irq_high && o_irq_valid
      && o_irq_source == $past(first_set(high_pend)))
    else $error("high level request not chosen first");
  a_prio_readback: assert property (i_wr && i_addr == intc_pkg::OFS_BASIC_PRIO
      ##1 i_rd && i_addr == intc_pkg::OFS_BASIC_PRIO && !i_wr
      |=> o_rdata == {1'b0, $past(i_wdata, 2) & 8'h7F})
    else $error("basic priority readback wrong");

  c_pin_request:  cover property (edge1[2] ##2 st_ff.pin1_req);
  c_high_beats:   cover property (o_irq_valid && o_irq_high && o_irq_source != 4'h0);
  c_tmr1_vector:  cover property (st_ff.tmr1_ovf ##1 i_vector_ack ##1 !st_ff.tmr1_ovf);

endmodule : intc_core

// ---- testbench/cpu_vector_model.sv ----
`timescale 1ns/10ps

// ==========================================================
// CPU side: takes the chosen request and enters its vector
module cpu_vector_model (
  // Clock and reset
  input  wire logic       i_clk,
  input  wire logic       i_sys_rst,
  // Request from the controller
  input  wire logic       i_irq_valid,
  input  wire logic [3:0] i_irq_source,
  // Behaviour knobs from the bench
  input  wire logic       i_ack_en,
  input  wire logic [3:0] i_ack_delay,
  // Vector entry towards the controller
  output logic            o_vector_ack,
  output logic [3:0]      o_vector_source
);
  logic [3:0] stall_ff;  // Cycles waited so far, models a slow core
  logic [1:0] hold_ff;   // Quiet time after entry, so a cleared flag can drop

  // ==========================================================
  // One entry per request; source bus idles at 4'hF, not a valid index
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      stall_ff        <= 4'h0;
      hold_ff         <= 2'h0;
      o_vector_ack    <= 1'b0;
      o_vector_source <= 4'hF;
    end else if (o_vector_ack) begin
      // Entry pulse lasts one cycle, then the bus idles again
      o_vector_ack    <= 1'b0;
      o_vector_source <= 4'hF;
      hold_ff         <= 2'h3;
    end else if (hold_ff != 2'h0) begin
      hold_ff <= hold_ff - 2'h1;
    end else if (i_ack_en && i_irq_valid) begin
      if (stall_ff == i_ack_delay) begin
        // Enter the source presented at this sampling edge
        o_vector_ack    <= 1'b1;
        o_vector_source <= i_irq_source;
        stall_ff        <= 4'h0;
      end else begin
        stall_ff <= stall_ff + 4'h1;
      end
    end
  end
endmodule : cpu_vector_model

// ---- testbench/interrupt_priority_flag_pin_expansion_test.sv ----
`timescale 1ns/10ps

module interrupt_priority_flag_pin_expansion_test;
  // ==========================================================
  // Bench signals
  logic clk, sys_rst, wr_stb, rd_stb, i2cm_evt, t0_ovf, t1_ovf, ack_en;
  logic t2_flag, wdog_flag, uart0_req, uart2_req, vec_ack, irq_valid, irq_high, run0, run1;
  logic [7:0]  addr, wdata, rdata;
  logic [3:0]  pins0, cfg0, ack_dly, vec_src, irq_src;
  logic [5:0]  pins1, cfg1;
  logic [14:0] src_en;
  intc_pkg::periph_flags_type pflags;
  int          err_count, checked, i;
  // Reset sweep offsets, last one unmapped
  logic [7:0]  ofs [9]   = '{8'h88, 8'h91, 8'h96, 8'h97, 8'hAE, 8'hAF, 8'hB8, 8'hF8, 8'h90};
  // One source bit per peripheral group and its summary bit
  logic [20:0] pmask [6] = '{21'h080000, 21'h004000, 21'h002000, 21'h000040, 21'h000020, 21'h000001};
  logic [7:0]  pbit [6]  = '{8'h80, 8'h40, 8'h20, 8'h08, 8'h04, 8'h02};
  // Arbitration rows: basic level, extended level, expected level and winner
  logic [7:0]  bp [5]    = '{8'h00, 8'h40, 8'h20, 8'h00, 8'h60};
  logic [7:0]  ep [5]    = '{8'h00, 8'h00, 8'h00, 8'h10, 8'h10};
  logic        eh [5]    = '{1'b0, 1'b1, 1'b1, 1'b1, 1'b1};
  logic [3:0]  es [5]    = '{4'h4, 4'h6, 4'h5, 4'hB, 4'h5};

  always #5 clk = ~clk;

  intc_core uut (
    .i_clk(clk), .i_sys_rst(sys_rst), .i_addr(addr), .i_wdata(wdata), .i_wr(wr_stb),
    .i_rd(rd_stb), .o_rdata(rdata), .i_periph_flags(pflags), .i_i2c_master_event(i2cm_evt),
    .i_timer0_overflow(t0_ovf), .i_timer1_overflow(t1_ovf), .i_timer2_flag(t2_flag),
    .i_watchdog_flag(wdog_flag), .i_uart0_request(uart0_req), .i_uart2_request(uart2_req),
    .i_pin_group0(pins0), .i_pin_group1(pins1), .i_pin_edge_config0(cfg0),
    .i_pin_edge_config1(cfg1), .i_source_enables(src_en), .i_vector_ack(vec_ack),
    .i_vector_source(vec_src), .o_irq_valid(irq_valid), .o_irq_high(irq_high),
    .o_irq_source(irq_src), .o_timer0_run(run0), .o_timer1_run(run1));

  cpu_vector_model cpu (
    .i_clk(clk), .i_sys_rst(sys_rst), .i_irq_valid(irq_valid), .i_irq_source(irq_src),
    .i_ack_en(ack_en), .i_ack_delay(ack_dly), .o_vector_ack(vec_ack),
    .o_vector_source(vec_src));

  // ==========================================================
  // Access tasks and checks
  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
    checked++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : chk

  task automatic reg_write(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    addr   <= a;
    wdata  <= d;
    wr_stb <= 1'b1;
    @(posedge clk);
    wr_stb <= 1'b0;
  endtask : reg_write

  // Read data stands only in the cycle after the strobe
  task automatic reg_read(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk);
    addr   <= a;
    rd_stb <= 1'b1;
    @(posedge clk);
    rd_stb <= 1'b0;
    #1;
    chk(rdata, e, "register read");
  endtask : reg_read

  // Margin of three edges covers request and arbitration stages
  task automatic irq_chk(input logic v, input logic h, input logic [3:0] s);
    repeat (3) @(posedge clk);
    #1;
    chk({2'b00, irq_valid, irq_high, irq_src}, {2'b00, v, h, s}, "request output");
  endtask : irq_chk

  // Bounded wait for the core model to enter a vector
  task automatic wait_ack(input logic [3:0] s);
    int n;
    for (n = 0; n < 20; n++) begin
      @(posedge clk);
      #1;
      if (vec_ack === 1'b1) break;
    end
    chk({3'b000, vec_ack, vec_src}, {4'b0001, s}, "vector entry");
  endtask : wait_ack

  task automatic stop_test;
    $display("comparisons %0d mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : stop_test

  // ==========================================================
  // Watchdog: the whole run needs well under 2000 cycles
  initial begin
    repeat (5000) @(posedge clk);
    err_count++;
    stop_test();
  end

  // ==========================================================
  // Test sequence
  initial begin
    {clk, sys_rst} = 2'b01;
    {wr_stb, rd_stb, i2cm_evt, t0_ovf, t1_ovf, ack_en} = '0;
    {t2_flag, wdog_flag, uart0_req, uart2_req} = '0;
    {addr, wdata, pins0, cfg0, ack_dly, pins1, cfg1, src_en} = '0;
    pflags = '0;
    repeat (3) @(posedge clk);
    sys_rst <= 1'b0;
    irq_chk(1'b0, 1'b0, 4'h0);
    // Reset values and unmapped read
    for (i = 0; i < 9; i++) begin
      reg_read(ofs[i], 8'h00);
    end
    reg_write(8'hB8, 8'hFF);
    reg_read(8'hB8, 8'h7F);
    reg_write(8'hF8, 8'hA5);
    reg_read(8'hF8, 8'hA5);
    reg_write(8'h96, 8'hFF);
    reg_read(8'h96, 8'h0F);
    reg_write(8'hAE, 8'hFF);
    reg_read(8'hAE, 8'h3F);
    @(posedge clk);
    #1;
    chk(rdata, 8'h00, "idle read data");
    reg_write(8'h90, 8'hFF);
    reg_read(8'h90, 8'h00);
    for (i = 0; i < 4; i++) begin
      reg_write(ofs[i + 4] ^ 8'h00, 8'h00);
    end
    reg_write(8'hB8, 8'h00);
    reg_write(8'hF8, 8'h00);
    reg_write(8'h96, 8'h00);
    $display("test registers finished");
    // Peripheral summary flags, one group at a time
    for (i = 0; i < 6; i++) begin
      @(posedge clk);
      pflags <= intc_pkg::periph_flags_type'(pmask[i]);
      reg_read(8'h91, pbit[i]);
      reg_write(8'h91, 8'h00);
      reg_read(8'h91, pbit[i]);
    end
    @(posedge clk);
    pflags <= intc_pkg::periph_flags_type'(21'h0C0000);
    src_en <= 15'h4000;
    reg_read(8'h91, 8'h80);
    @(posedge clk);
    pflags <= intc_pkg::periph_flags_type'(21'h040000);
    reg_read(8'h91, 8'h80);
    irq_chk(1'b1, 1'b0, 4'hE);
    @(posedge clk);
    pflags <= '0;
    reg_read(8'h91, 8'h00);
    irq_chk(1'b0, 1'b0, 4'h0);
    $display("test peripheral flags finished");
    // I2C master flag survives its own vector entry
    @(posedge clk);
    i2cm_evt <= 1'b1;
    @(posedge clk);
    i2cm_evt <= 1'b0;
    reg_read(8'h91, 8'h01);
    reg_write(8'h91, 8'hFF);
    reg_read(8'h91, 8'h01);
    @(posedge clk);
    src_en  <= 15'h0080;
    ack_en  <= 1'b1;
    ack_dly <= 4'h2;
    wait_ack(4'h7);
    @(posedge clk);
    ack_en <= 1'b0;
    reg_read(8'h91, 8'h01);
    reg_write(8'h91, 8'h00);
    reg_read(8'h91, 8'h00);
    $display("test i2c master flag finished");
    // Timer overflow flags cleared by vector entry, prompt and slow core
    @(posedge clk);
    t0_ovf <= 1'b1;
    @(posedge clk);
    t0_ovf <= 1'b0;
    reg_read(8'h88, 8'h20);
    reg_write(8'h88, 8'hFF);
    reg_read(8'h88, 8'h70);
    chk({6'h00, run1, run0}, 8'h03, "timer run bits");
    @(posedge clk);
    src_en  <= 15'h000A;
    ack_en  <= 1'b1;
    ack_dly <= 4'h0;
    wait_ack(4'h1);
    @(posedge clk);
    ack_en <= 1'b0;
    t1_ovf <= 1'b1;
    @(posedge clk);
    t1_ovf <= 1'b0;
    reg_read(8'h88, 8'hD0);
    @(posedge clk);
    ack_en  <= 1'b1;
    ack_dly <= 4'h5;
    wait_ack(4'h3);
    @(posedge clk);
    ack_en <= 1'b0;
    reg_read(8'h88, 8'h50);
    reg_write(8'h88, 8'h00);
    reg_read(8'h88, 8'h00);
    $display("test timer flags finished");
    // Pin group 0: disabled pin still latches, then request and clearing order
    @(posedge clk);
    cfg0   <= 4'h5;
    src_en <= 15'h0001;
    pins0  <= 4'h1;
    reg_read(8'h97, 8'h01);
    reg_read(8'h88, 8'h00);
    reg_write(8'h96, 8'h0F);
    reg_read(8'h88, 8'h02);
    irq_chk(1'b1, 1'b0, 4'h0);
    @(posedge clk);
    pins0 <= 4'h3;
    reg_read(8'h97, 8'h01);
    @(posedge clk);
    pins0 <= 4'h1;
    reg_read(8'h97, 8'h03);
    reg_write(8'h88, 8'h00);
    reg_read(8'h88, 8'h02);
    reg_write(8'h97, 8'h02);
    reg_read(8'h97, 8'h02);
    reg_read(8'h88, 8'h02);
    reg_write(8'h97, 8'h00);
    reg_read(8'h88, 8'h00);
    irq_chk(1'b0, 1'b0, 4'h0);
    // Pin group 1: falling edge only
    @(posedge clk);
    pins1 <= 6'h20;
    reg_read(8'hAF, 8'h00);
    @(posedge clk);
    pins1 <= 6'h00;
    reg_read(8'hAF, 8'h20);
    reg_write(8'hAE, 8'h20);
    reg_read(8'h88, 8'h08);
    reg_write(8'hAF, 8'h00);
    reg_read(8'hAF, 8'h00);
    reg_read(8'h88, 8'h00);
    $display("test pin groups finished");
    // Arbitration between four level sources
    @(posedge clk);
    {uart0_req, uart2_req, t2_flag, wdog_flag} <= 4'hF;
    src_en <= 15'h0870;
    for (i = 0; i < 5; i++) begin
      reg_write(8'hB8, bp[i]);
      reg_write(8'hF8, ep[i]);
      irq_chk(1'b1, eh[i], es[i]);
    end
    @(posedge clk);
    src_en <= 15'h0000;
    irq_chk(1'b0, 1'b0, 4'h0);
    @(posedge clk);
    src_en <= 15'h0870;
    {uart0_req, uart2_req, t2_flag, wdog_flag} <= 4'h0;
    irq_chk(1'b0, 1'b0, 4'h0);
    $display("test arbitration finished");
    stop_test();
  end
endmodule : interrupt_priority_flag_pin_expansion_test
